// ---- design/sadc_pkg.sv ----
package sadc_pkg;
    // Register addresses.
    localparam logic [15:0] ADDR_RESULT_WORD = 16'hff08;
    localparam logic [15:0] ADDR_RESULT_HIGH = 16'hff09;
    localparam logic [15:0] ADDR_CHANNEL_SELECT = 16'hff29;
    localparam logic [15:0] ADDR_MODE = 16'hff28;
    localparam logic [15:0] ADDR_RESULT_HIGH_BYTE = 16'hff1f;
    // Mode, channel and result register fields.
    localparam int MODE_CONV_RUN = 7;
    localparam int MODE_RATE_LSB = 3;
    localparam int MODE_REF_LSB = 1;
    localparam int MODE_COMPARATOR_ON = 0;
    localparam logic [7:0] MODE_WMASK = 8'hbf;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CHANNEL_RESET = 8'h00;
    localparam logic [2:0] CHANNEL_WMASK = 3'h7;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam int RESULT_BITS = 10;
    localparam int RESULT_PAD = 6;
    // Conversion sequencing.
    localparam logic [2:0] RATE_MAX = 3'h5;
    localparam logic [5:0] CONV_CLKS_REF0 = 6'h16;
    localparam logic [5:0] CONV_CLKS_REF1 = 6'h28;
    localparam logic [5:0] COMPARE_STEPS = 6'h0a;
    localparam logic [3:0] DIV_12 = 4'hc;
    localparam logic [3:0] DIV_8 = 4'h8;
    localparam logic [3:0] DIV_6 = 4'h6;
    localparam logic [3:0] DIV_4 = 4'h4;
    localparam logic [3:0] DIV_3 = 4'h3;
    localparam logic [3:0] DIV_2 = 4'h2;
endpackage

// ---- design/sadc_sar_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface sadc_sar_if;
    logic run;
    logic [3:0] div;
    logic [5:0] nconv;
    logic cmp_hi;
    logic [9:0] trial;
    logic sampling;
    logic done;
    logic [9:0] result;
    modport ctl (output run, output div, output nconv, output cmp_hi,
                 input trial, input sampling, input done, input result);
    modport eng (input run, input div, input nconv, input cmp_hi,
                 output trial, output sampling, output done, output result);
endinterface
`default_nettype wire

// ---- design/sadc_sar_engine.sv ----
`timescale 1ns/1ns
`default_nettype none
module sadc_sar_engine
    import sadc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Controller side.
    sadc_sar_if.eng sar
);
    typedef struct packed {
        logic [3:0] pre;
        logic [5:0] step;
        logic [9:0] approx;
        logic done;
        logic [9:0] result;
    } sadc_eng_type;

    sadc_eng_type st_ff;
    sadc_eng_type nxt_st;
    logic tick;
    logic [5:0] cmp_start;
    logic [3:0] bit_idx;
    logic comparing;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        tick = (st_ff.pre == sar.div - 4'h1);
        cmp_start = sar.nconv - COMPARE_STEPS;
        comparing = (st_ff.step >= cmp_start);
        bit_idx = 4'h9 - 4'(st_ff.step - cmp_start);
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        if (!sar.run)
        begin
            // Stopping or a control write discards the conversion in flight.
            nxt_st.pre = 4'h0;
            nxt_st.step = 6'h0;
            nxt_st.approx = 10'h000;
        end
        else if (!tick)
        begin
            nxt_st.pre = st_ff.pre + 4'h1;
        end
        else
        begin
            nxt_st.pre = 4'h0;
            nxt_st.step = st_ff.step + 6'h1; // (R19)
            if (comparing)
            begin
                nxt_st.approx[bit_idx] = sar.cmp_hi; // (R18)
                if (bit_idx == 4'h0)
                begin
                    nxt_st.result = {st_ff.approx[9:1], sar.cmp_hi}; // (R07)
                    nxt_st.done = 1'b1; // (R16)
                    nxt_st.step = 6'h0; // (R17)
                    nxt_st.approx = 10'h000;
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign sar.trial = comparing ? (st_ff.approx | (10'h001 << bit_idx)) : 10'h000;
    assign sar.sampling = sar.run && !comparing;
    assign sar.done = st_ff.done;
    assign sar.result = st_ff.result;
endmodule
`default_nettype wire

// ---- design/sadc_top.sv ----
// How it works
// (R01) Reference 00: rate codes 0-5 divide by 12,8,6,4,3,2; 264..44 clocks.
// (R02) Reference 01: same dividers, conversion times 480..80 clocks.
// (R03) Software stops conversion before changing rate or reference fields.
// (R04) Software keeps conversion clock within its voltage-dependent range.
// (R05) Result word holds 10 bits left-justified, low 6 bits zero.
// (R06) Upper 8 bits at high byte, lower 2 bits top of low byte.
// (R07) Each conversion end loads the approximation value into the result.
// (R08) Result word is read only as 16-bit access, resets to zero.
// (R09) Result high byte mirrors upper 8 result bits, updated each completion.
// (R10) Result high byte reads with 8-bit access, resets to zero.
// (R11) Writing mode or channel may spoil result; read result before.
// (R12) Result reads and channel writes insert one bus wait cycle.
// (R13) Channel register resets zero, bit/byte writable, 3-bit binary channel code.
// (R14) Software writes zero to channel register bits 3 to 7.
// (R15) Six-input variant: software avoids channel codes 110 and 111.
// (R16) Conversion-done interrupt request pulses at every completion.
// (R17) Conversions repeat while run bit set; clearing it stops them.
// (R18) Approximation resolves bit 9 down to bit 0, one per comparison.
// (R19) Sequence uses 22 conversion clocks (range 00) or 40 (range 01).
// (R20) Illegal rate or reference codes fall back to nearest legal setting.
`timescale 1ns/1ns
`default_nettype none
module sadc_top
    import sadc_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Memory-mapped register access.
    input wire logic bus_req,
    input wire logic bus_we,
    input wire logic bus_size16,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_wmask,
    output logic bus_ready,
    output logic [15:0] bus_rdata,
    // Analog front end.
    input wire logic comparator_hi,
    output logic [2:0] channel_code,
    output logic sample_hold,
    output logic [9:0] tap_code,
    output logic comparator_on,
    // Events.
    output logic conv_done_irq
);
    typedef struct packed {
        logic [7:0] mode;
        logic [2:0] chan;
        logic [9:0] result;
        logic waited;
        logic [15:0] rdata;
    } sadc_top_type;

    sadc_top_type st_ff;
    sadc_top_type nxt_st;
    sadc_sar_if sar ();
    logic [2:0] rate;
    logic ref_low;
    logic needs_wait;
    logic take;
    logic wr_mode;
    logic wr_chan;
    logic sel_word;
    logic sel_high;
    logic sel_mode;
    logic sel_chan;
    logic [15:0] rd_value;

    sadc_sar_engine u_engine (
        .clk(clk),
        .sys_rst(sys_rst),
        .sar(sar)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Conversion clock selection.
    always_comb
    begin
        rate = st_ff.mode[MODE_RATE_LSB +: 3];
        // Codes past the table run at the fastest divider; no accuracy is promised there.
        if (rate > RATE_MAX)
        begin
            rate = RATE_MAX; // (R20)
        end
        // Any nonzero reference code is treated as the low range.
        ref_low = |st_ff.mode[MODE_REF_LSB +: 2]; // (R20)
        case (rate)
            3'h0: sar.div = DIV_12; // (R01)
            3'h1: sar.div = DIV_8;
            3'h2: sar.div = DIV_6;
            3'h3: sar.div = DIV_4;
            3'h4: sar.div = DIV_3;
            default: sar.div = DIV_2;
        endcase
        sar.nconv = ref_low ? CONV_CLKS_REF1 : CONV_CLKS_REF0; // (R02)
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode and wait insertion.
    always_comb
    begin
        sel_word = (bus_addr == ADDR_RESULT_WORD);
        sel_high = (bus_addr == ADDR_RESULT_HIGH_BYTE);
        sel_mode = (bus_addr == ADDR_MODE);
        sel_chan = (bus_addr == ADDR_CHANNEL_SELECT);
        needs_wait = (!bus_we && (sel_word || sel_high)) || (bus_we && sel_chan); // (R12)
        bus_ready = !(needs_wait && !st_ff.waited); // (R12)
        take = bus_req && bus_ready;
        wr_mode = take && bus_we && sel_mode;
        wr_chan = take && bus_we && sel_chan;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data selection. A result read of the wrong width returns zero rather
    // than half a result, which software could mistake for a small reading.
    always_comb
    begin
        rd_value = RESULT_RESET;
        if (sel_word)
        begin
            if (bus_size16)
            begin
                rd_value = {st_ff.result, RESULT_PAD'(0)}; // (R05) (R06) (R08)
            end
        end
        else if (sel_high)
        begin
            if (!bus_size16)
            begin
                rd_value = {8'h00, st_ff.result[9:2]}; // (R09) (R10)
            end
        end
        else if (sel_mode)
        begin
            rd_value = {8'h00, st_ff.mode};
        end
        else if (sel_chan)
        begin
            rd_value = {13'h0000, st_ff.chan};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register updates.
    always_comb
    begin
        nxt_st = st_ff;
        // The wait flag lives for one cycle only, so every result read or channel write waits afresh.
        nxt_st.waited = bus_req && needs_wait && !st_ff.waited; // (R12)
        if (wr_mode)
        begin
            nxt_st.mode = (st_ff.mode & ~(bus_wmask & MODE_WMASK))
                          | (bus_wdata & bus_wmask & MODE_WMASK);
        end
        if (wr_chan)
        begin
            // Upper bits are not stored so they always read back as zero.
            nxt_st.chan = (st_ff.chan & ~(bus_wmask[2:0] & CHANNEL_WMASK))
                          | (bus_wdata[2:0] & bus_wmask[2:0]); // (R13)
        end
        if (sar.done)
        begin
            nxt_st.result = sar.result; // (R07)
        end
        if (take && !bus_we)
        begin
            nxt_st.rdata = rd_value;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_ff.mode <= MODE_RESET;
            st_ff.chan <= CHANNEL_RESET[2:0]; // (R13)
            st_ff.result <= RESULT_RESET[15:6]; // (R08) (R10)
            st_ff.waited <= 1'b0;
            st_ff.rdata <= RESULT_RESET;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Converter hookup. A mode or channel write restarts the running
    // conversion, so a result never mixes two channels or two rates.
    assign sar.run = st_ff.mode[MODE_CONV_RUN] && !wr_mode && !wr_chan; // (R11) (R17)
    assign sar.cmp_hi = comparator_hi;
    assign bus_rdata = st_ff.rdata;
    assign channel_code = st_ff.chan;
    assign sample_hold = sar.sampling;
    assign tap_code = sar.trial;
    assign comparator_on = st_ff.mode[MODE_COMPARATOR_ON];
    assign conv_done_irq = sar.done; // (R16)
endmodule
`default_nettype wire

// ---- dv/sadc_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module sadc_chk
    import sadc_pkg::*;
(
    // Watched ports.
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic bus_req,
    input wire logic bus_we,
    input wire logic [15:0] bus_addr,
    input wire logic bus_ready,
    input wire logic [15:0] bus_rdata,
    input wire logic [2:0] channel_code,
    input wire logic sample_hold,
    input wire logic [9:0] tap_code,
    input wire logic conv_done_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_rd(a);
        bus_req && bus_ready && !bus_we && bus_addr == a;
    endsequence
    a_irq_gap: assert property (conv_done_irq |=> !conv_done_irq [*8])
        else $error("done pulses too close");
    a_irq_after_lsb: assert property (conv_done_irq |-> $past(tap_code[0]))
        else $error("done without last trial");
    a_hold_no_tap: assert property (sample_hold |-> tap_code == 10'h000)
        else $error("trial during sampling");
    a_msb_first: assert property ($fell(sample_hold) && tap_code != 0 |-> tap_code == 10'h200)
        else $error("first trial not msb");
    a_wait_first: assert property (bus_req && !$past(bus_req) && !bus_we
        && bus_addr == ADDR_RESULT_WORD |-> !bus_ready)
        else $error("no wait cycle");
    a_wait_ends: assert property (bus_req |-> ##[0:1] bus_ready)
        else $error("wait too long");
    a_word_pad: assert property (s_rd(ADDR_RESULT_WORD) |=> bus_rdata[5:0] == 6'h00)
        else $error("word pad not zero");
    a_high_byte: assert property (s_rd(ADDR_RESULT_HIGH_BYTE) |=> bus_rdata[15:8] == 8'h00)
        else $error("high byte read too wide");
    a_chan_by_write: assert property ($changed(channel_code)
        |-> $past(bus_req && bus_we && bus_ready))
        else $error("channel moved alone");
    a_rd_holds: assert property ($changed(bus_rdata)
        |-> $past(bus_req && bus_ready && !bus_we))
        else $error("read data moved alone");
endmodule
bind sadc_top sadc_chk u_chk (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .bus_we(bus_we), .bus_addr(bus_addr), .bus_ready(bus_ready), .bus_rdata(bus_rdata),
    .channel_code(channel_code), .sample_hold(sample_hold), .tap_code(tap_code),
    .conv_done_irq(conv_done_irq));
`default_nettype wire

// ---- dv/sadc_afe_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module sadc_afe_model (
    // Converter side.
    input wire logic clk,
    input wire logic [2:0] channel_code,
    input wire logic sample_hold,
    input wire logic [9:0] tap_code,
    output logic comparator_hi,
    // Scenario side. All eight inputs are modelled, so channel codes 6 and 7 are legal.
    input wire logic [79:0] levels
);
    logic [9:0] held;
    logic junk = 1'b0;
    // Outside a trial the output toggles, so the design cannot lean on a stale answer.
    always @(posedge clk)
    begin
        junk <= !junk;
        if (sample_hold)
            held <= levels[channel_code * 10 +: 10];
    end
    assign comparator_hi = (tap_code != 10'h000) ? (held >= tap_code) : junk;
endmodule
`default_nettype wire

// ---- dv/sadc_top_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module sadc_top_bench;
    import sadc_pkg::*;
    logic clk, sys_rst, bus_req, bus_we, bus_size16, comparator_hi, bus_ready;
    logic sample_hold, comparator_on, conv_done_irq;
    logic [15:0] bus_addr, bus_rdata, rd;
    logic [7:0] bus_wdata, bus_wmask;
    logic [2:0] channel_code, ch;
    logic [9:0] tap_code, lvl;
    logic [7:0] mode_v;
    logic [79:0] levels;
    int n_mismatch = 0, compares = 0, seed = 34, cnt, seen;
    sadc_top u_dut (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_we(bus_we),
        .bus_size16(bus_size16), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wmask(bus_wmask), .bus_ready(bus_ready), .bus_rdata(bus_rdata),
        .comparator_hi(comparator_hi), .channel_code(channel_code),
        .sample_hold(sample_hold), .tap_code(tap_code), .comparator_on(comparator_on),
        .conv_done_irq(conv_done_irq));
    sadc_afe_model u_afe (.clk(clk), .channel_code(channel_code), .sample_hold(sample_hold),
        .tap_code(tap_code), .comparator_hi(comparator_hi), .levels(levels));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = !clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task give_verdict;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic int conv_cycles(input int rate, input int rng);
        int divs[6] = '{12, 8, 6, 4, 3, 2};
        return divs[rate] * (rng != 0 ? 40 : 22);
    endfunction
    // Request is held from a falling edge until the rising edge that sees ready.
    task bus(input logic we, input logic sz, input logic [15:0] a, input logic [7:0] d,
        input logic [7:0] m);
        @(negedge clk);
        {bus_req, bus_we, bus_size16, bus_addr, bus_wdata, bus_wmask} = {1'b1, we, sz, a, d, m};
        repeat (4)
        begin
            #1;
            if (bus_ready)
                break;
            @(negedge clk);
        end
        if (!bus_ready)
        begin
            n_mismatch++;
            give_verdict;
        end
        @(negedge clk);
        bus_req = 1'b0;
        rd = bus_rdata;
    endtask
    task wait_irq;
        cnt = 0;
        do
        begin
            @(negedge clk);
            cnt++;
        end while (!conv_done_irq && cnt < 1000);
        if (!conv_done_irq)
        begin
            n_mismatch++;
            give_verdict;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {bus_req, bus_we, bus_size16, bus_addr, bus_wdata, bus_wmask} = '0;
        sys_rst = 1'b1;
        levels = 80'({$random(seed), $random(seed), $random(seed)});
        levels[19:0] = 20'h003ff;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        bus(0, 1, ADDR_RESULT_WORD, 0, 0);
        chk("word reset", RESULT_RESET, rd);
        bus(0, 0, ADDR_RESULT_HIGH_BYTE, 0, 0);
        chk("high reset", 16'h0000, rd);
        bus(0, 0, ADDR_CHANNEL_SELECT, 0, 0);
        chk("chan reset", {8'h00, CHANNEL_RESET}, rd);
        for (int c = 0; c < 8; c++)
        begin
            bus(1, 0, ADDR_CHANNEL_SELECT, 8'(c), 8'hff);
            bus(0, 0, ADDR_CHANNEL_SELECT, 0, 0);
            chk("chan read", 16'(c), rd);
            chk("chan pin", 16'(c), 16'(channel_code));
        end
        bus(1, 0, ADDR_CHANNEL_SELECT, 8'h00, 8'h02);
        chk("chan bit", 16'h0005, 16'(channel_code));
        $display("register test done");
        for (int r = 0; r < 12; r++)
        begin
            ch = (r < 2) ? 3'(r) : 3'($random(seed));
            lvl = levels[ch * 10 +: 10];
            // Only the run bit is written, so rate and range never change while running.
            bus(1, 0, ADDR_MODE, 8'h00, 8'h80);
            bus(1, 0, ADDR_CHANNEL_SELECT, {5'h00, ch}, 8'hff);
            mode_v = {2'h2, 3'(r % 6), 2'(r / 6), 1'($random(seed))};
            // The model has no analog settling, so the conversion clock may exceed its range.
            bus(1, 0, ADDR_MODE, mode_v, 8'hff);
            wait_irq;
            chk("first done", 16'(conv_cycles(r % 6, r / 6)), 16'(cnt));
            wait_irq;
            chk("repeat done", 16'(conv_cycles(r % 6, r / 6)), 16'(cnt));
            bus(0, 1, ADDR_RESULT_WORD, 0, 0);
            chk("word", {lvl, 6'h00}, rd);
            bus(0, 0, ADDR_RESULT_HIGH_BYTE, 0, 0);
            chk("high", {8'h00, lvl[9:2]}, rd);
            bus(0, 0, ADDR_MODE, 0, 0);
            chk("mode", {8'h00, mode_v}, rd);
            chk("comparator on", 16'(mode_v[MODE_COMPARATOR_ON]), 16'(comparator_on));
            $display("conversion test %0d done", r);
        end
        bus(0, 0, ADDR_RESULT_WORD, 0, 0);
        chk("word narrow", 16'h0000, rd);
        bus(0, 1, 16'hff00, 0, 0);
        chk("unmapped", 16'h0000, rd);
        bus(1, 0, ADDR_MODE, 8'h00, 8'h80);
        seen = 0;
        repeat (600) @(negedge clk) seen += int'(conv_done_irq);
        chk("stopped", 16'h0000, 16'(seen));
        $display("stop test done");
        give_verdict;
    end
endmodule
`default_nettype wire
